/* logic/emac_dp_pkg.sv */
// Constants, register map and carrier types for the MAC data-path block.
// Assumes a single 250 MHz clock shared with the bus and the wire logic.
//
// Functional notes
// RULE1 - No resources at frame start: count, discard
// RULE2 - Mid-frame shortfall: discard and count by default
// RULE3 - Matching, no error copy: discard, still count
// RULE4 - Unmatched, copy-all and error copy: partial promiscuous
// RULE5 - Matching with error copy: partial, overrun flag
// RULE6 - At maximum length it is truncation, not overrun
// RULE7 - Eight transmit channels, fixed or rotating priority
// RULE8 - Fixed: highest numbered pending channel first
// RULE9 - Rotating: ascending 0 to 7, then wrap
// RULE10 - Host initialises addresses, pointers, masks, descriptors
// RULE11 - Host enables transmit DMA before head pointers
// RULE12 - Shutdown by channel number, accepted anytime
// RULE13 - Frame in flight finishes before channel stops
// RULE14 - Mark next start descriptor, only if present
// RULE15 - Clear head, raise interrupt, load completion value
// RULE16 - Host acknowledges with the completion value
// RULE17 - Shutdown leaves every channel enable alone
// RULE18 - Inactive channel shutdown still interrupts, no descriptor
// RULE19 - Completion pointer reads the shutdown value
// RULE20 - Transmit 24 cells, receive 68 cells, 64 bytes
// RULE21 - Start at cell level or complete packet
// RULE22 - Level 24 waits for whole maximum packet
// RULE23 - Interrupt only after head pointer cleared

`default_nettype none

package emac_dp_pkg;

  // Channel count and cell storage sizes
  localparam int NUM_CH = 8;
  localparam int CH_W = 3;
  localparam int TX_CELLS = 24; // RULE20
  localparam int RX_CELLS = 68; // RULE20
  localparam int CELL_BYTES = 64;
  localparam int LVL_W = 5;
  localparam logic [LVL_W-1:0] CELL_LVL_RST = 5'h18;

  // Register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] MAC_CONFIG_OFS = 8'h00;
  localparam logic [7:0] DMA_CONTROL_OFS = 8'h04;
  localparam logic [7:0] RX_FILTER_OFS = 8'h08;
  localparam logic [7:0] FIFO_CONFIG_OFS = 8'h0c;
  localparam logic [7:0] SHUTDOWN_OFS = 8'h10;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h14;
  localparam logic [7:0] SOF_CNT_OFS = 8'h18;
  localparam logic [7:0] MOF_CNT_OFS = 8'h1c;
  localparam logic [7:0] DMA_CNT_OFS = 8'h20;
  localparam logic [7:0] HEAD_BASE = 8'h40;
  localparam logic [7:0] COMP_BASE = 8'h60;

  // Field positions
  localparam int PRIO_SEL_BIT = 0;
  localparam int DMA_EN_BIT = 0;
  localparam int COPY_ALL_BIT = 0;
  localparam int ERR_COPY_BIT = 1;

  // Shutdown completion value and bus answers
  localparam logic [31:0] DONE_VALUE = 32'hffff_fffc;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Receive overrun verdict toward the receive DMA
  typedef struct packed {
    logic discard;
    logic partial;
    logic to_promisc;
    logic ovr_flag;
    logic unmatched_frame_flag_flag;
  } rx_verdict_t;

  // Shutdown-done flag write into a start descriptor
  typedef struct packed {
    logic [CH_W-1:0] chan;
    logic [31:0] desc_addr;
  } sd_flag_t;

endpackage : emac_dp_pkg

`default_nettype wire

/* logic/emac_dp_core.sv */
// Receive overrun verdicts, transmit channel scheduling and shutdown,
// transmit start threshold, all behind an AXI4-Lite register slave.
// Assumes wire-side and DMA-side inputs come from logic on aclk.
//
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.

`default_nettype none

module emac_dp_core
  import emac_dp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic tx_sched_req,
  output logic tx_grant_valid,
  output logic [CH_W-1:0] tx_grant_chan,
  input wire logic tx_busy,
  input wire logic [CH_W-1:0] tx_busy_chan,
  output logic sd_flag_valid,
  output sd_flag_t sd_flag,
  output logic tx_irq,
  input wire logic [LVL_W-1:0] tx_cells_present,
  input wire logic tx_packet_complete,
  output logic tx_start,
  input wire logic rx_frame_start,
  input wire logic rx_frame_end,
  input wire logic rx_res_avail,
  input wire logic rx_res_exhausted,
  input wire logic rx_addr_match,
  input wire logic rx_at_max_len,
  input wire logic rx_dma_short,
  output logic rx_verdict_valid,
  output rx_verdict_t rx_verdict,
  output logic rx_truncate
);

  // ****************************************
  // Bus slave
  // ****************************************

  logic aw_ff, w_ff;
  logic [ADDR_W-1:0] awa_ff;
  logic [31:0] wd_ff;
  logic [3:0] ws_ff;
  logic bvalid_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic wr_en;
  logic [31:0] nxt_rdata;
  logic rd_hit;

  // Address lies in the map
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a[1:0] == 2'h0) &&
             ((a <= DMA_CNT_OFS) || (a >= HEAD_BASE &&
              a < COMP_BASE + 8'(4 * NUM_CH)));
  endfunction

  // Merge a write under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] st);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = st[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  assign awready = !aw_ff && !bvalid_ff;
  assign wready = !w_ff && !bvalid_ff;
  // Address and data may arrive in either order
  assign wr_en = aw_ff && w_ff && !bvalid_ff;

  // Write address and data holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awa_ff <= '0;
      wd_ff <= '0;
      ws_ff <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_ff <= 1'b1;
        awa_ff <= awaddr;
      end else if (wr_en) begin
        aw_ff <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ff <= 1'b1;
        wd_ff <= wdata;
        ws_ff <= wstrb;
      end else if (wr_en) begin
        w_ff <= 1'b0;
      end
    end
  end

  // Write response, one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (wr_en) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= mapped(awa_ff) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = !rvalid_ff;

  // ****************************************
  // Control registers
  // ****************************************

  logic prio_rr_ff, dma_en_ff, copy_all_ff, err_copy_ff;
  logic [LVL_W-1:0] cell_lvl_ff;

  // Software-steered configuration bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prio_rr_ff <= 1'b0;
      dma_en_ff <= 1'b0;
      copy_all_ff <= 1'b0;
      err_copy_ff <= 1'b0;
      cell_lvl_ff <= CELL_LVL_RST;
    end else if (wr_en && ws_ff[0]) begin
      case (awa_ff)
        MAC_CONFIG_OFS: prio_rr_ff <= wd_ff[PRIO_SEL_BIT]; // RULE7
        DMA_CONTROL_OFS: dma_en_ff <= wd_ff[DMA_EN_BIT]; // RULE17
        RX_FILTER_OFS: begin
          copy_all_ff <= wd_ff[COPY_ALL_BIT];
          err_copy_ff <= wd_ff[ERR_COPY_BIT];
        end
        FIFO_CONFIG_OFS: cell_lvl_ff <= wd_ff[LVL_W-1:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Transmit channel state
  // ****************************************

  logic [31:0] head_ff [NUM_CH];
  logic [31:0] comp_ff [NUM_CH];
  logic [NUM_CH-1:0] td_req_ff, irq_ff;
  logic td_go;
  logic [CH_W-1:0] td_ch;
  logic td_fire_ff;
  logic [CH_W-1:0] td_fire_ch_ff;
  logic [NUM_CH-1:0] pend;
  logic shut_wr;

  assign shut_wr = wr_en && ws_ff[0] && awa_ff == SHUTDOWN_OFS;

  // Lowest requested channel not carrying a frame may stop now
  always_comb begin
    td_go = 1'b0;
    td_ch = '0;
    for (int n = NUM_CH - 1; n >= 0; n--) begin
      if (td_req_ff[n] && !(tx_busy && tx_busy_chan == CH_W'(n))) begin
        td_go = 1'b1; // RULE13
        td_ch = CH_W'(n);
      end
    end
  end

  // Shutdown requests; a new request wins over its own completion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      td_req_ff <= '0;
    end else begin
      for (int n = 0; n < NUM_CH; n++) begin
        if (shut_wr && wd_ff[CH_W-1:0] == CH_W'(n)) begin
          td_req_ff[n] <= 1'b1; // RULE12
        end else if (td_go && td_ch == CH_W'(n)) begin
          td_req_ff[n] <= 1'b0;
        end
      end
    end
  end

  // Head and completion pointers; shutdown overrides a host write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int n = 0; n < NUM_CH; n++) begin
        head_ff[n] <= '0;
        comp_ff[n] <= '0;
      end
    end else begin
      for (int n = 0; n < NUM_CH; n++) begin
        if (td_go && td_ch == CH_W'(n)) begin
          head_ff[n] <= '0; // RULE15
          comp_ff[n] <= DONE_VALUE; // RULE15 RULE19
        end else if (wr_en) begin
          if (awa_ff == HEAD_BASE + 8'(4 * n)) begin
            head_ff[n] <= merge(head_ff[n], wd_ff, ws_ff);
          end
          if (awa_ff == COMP_BASE + 8'(4 * n)) begin
            comp_ff[n] <= merge(comp_ff[n], wd_ff, ws_ff);
          end
        end
      end
    end
  end

  // Descriptor flag only when a chain exists
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sd_flag_valid <= 1'b0;
      sd_flag <= '0;
    end else begin
      sd_flag_valid <= td_go && head_ff[td_ch] != '0; // RULE14 RULE18
      if (td_go) begin
        sd_flag.chan <= td_ch;
        sd_flag.desc_addr <= head_ff[td_ch];
      end
    end
  end

  // Interrupt follows the pointer update by one edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      td_fire_ff <= 1'b0;
      td_fire_ch_ff <= '0;
    end else begin
      td_fire_ff <= td_go; // RULE23
      td_fire_ch_ff <= td_ch;
    end
  end

  // Pending interrupt per channel; raise wins over acknowledge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ff <= '0;
    end else begin
      for (int n = 0; n < NUM_CH; n++) begin
        if (td_fire_ff && td_fire_ch_ff == CH_W'(n)) begin
          irq_ff[n] <= 1'b1; // RULE15 RULE18
        end else if (wr_en && awa_ff == COMP_BASE + 8'(4 * n) &&
                     ws_ff == 4'hf && wd_ff == DONE_VALUE) begin
          irq_ff[n] <= 1'b0; // RULE16
        end
      end
    end
  end

  assign tx_irq = |irq_ff;

  // ****************************************
  // Transmit scheduling
  // ****************************************

  logic [CH_W-1:0] last_ff;
  logic win_ok;
  logic [CH_W-1:0] win_ch;

  // Channel wants service while enabled and holding a chain
  always_comb begin
    for (int n = 0; n < NUM_CH; n++) begin
      pend[n] = dma_en_ff && head_ff[n] != '0 && !td_req_ff[n];
    end
  end

  // Pick the winner for the configured priority type
  always_comb begin
    logic [CH_W-1:0] c;
    win_ok = 1'b0;
    win_ch = '0;
    c = '0;
    if (prio_rr_ff) begin
      for (int k = NUM_CH; k >= 1; k--) begin
        c = last_ff + CH_W'(k); // RULE9
        if (pend[c]) begin
          win_ok = 1'b1;
          win_ch = c;
        end
      end
    end else begin
      for (int n = 0; n < NUM_CH; n++) begin
        if (pend[n]) begin
          win_ok = 1'b1; // RULE8
          win_ch = CH_W'(n);
        end
      end
    end
  end

  // Registered grant and rotation point
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_grant_valid <= 1'b0;
      tx_grant_chan <= '0;
      last_ff <= CH_W'(NUM_CH - 1);
    end else begin
      tx_grant_valid <= tx_sched_req && win_ok; // RULE7
      if (tx_sched_req && win_ok) begin
        tx_grant_chan <= win_ch;
        last_ff <= win_ch;
      end
    end
  end

  // Start once enough cells or the whole packet sit in the FIFO
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_start <= 1'b0;
    end else begin
      tx_start <= tx_packet_complete ||
                  tx_cells_present >= cell_lvl_ff; // RULE21 RULE22
    end
  end

  // ****************************************
  // Receive overrun handling
  // ****************************************

  logic in_frame_ff;
  logic [31:0] sof_cnt_ff, mof_cnt_ff, dma_cnt_ff;
  logic sof_ev, mof_ev;
  rx_verdict_t mof_v;

  assign sof_ev = rx_frame_start && !rx_res_avail; // RULE1
  // Reaching maximum length is truncation instead
  assign mof_ev = in_frame_ff && rx_res_exhausted &&
                  !rx_at_max_len; // RULE6

  // Mid-frame treatment from match and copy controls
  always_comb begin
    mof_v = '0;
    if (rx_addr_match && err_copy_ff) begin
      mof_v.partial = 1'b1; // RULE5
      mof_v.ovr_flag = 1'b1;
    end else if (!rx_addr_match && copy_all_ff && err_copy_ff) begin
      mof_v.partial = 1'b1; // RULE4
      mof_v.to_promisc = 1'b1;
      mof_v.ovr_flag = 1'b1;
      mof_v.unmatched_frame_flag_flag = 1'b1;
    end else begin
      mof_v.discard = 1'b1; // RULE2 RULE3
    end
  end

  // Frame tracking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_frame_ff <= 1'b0;
    end else if (rx_frame_start) begin
      in_frame_ff <= rx_res_avail;
    end else if (mof_ev || rx_frame_end) begin
      in_frame_ff <= 1'b0;
    end
  end

  // Verdict toward the receive DMA
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_verdict_valid <= 1'b0;
      rx_verdict <= '0;
      rx_truncate <= 1'b0;
    end else begin
      rx_verdict_valid <= sof_ev || mof_ev;
      rx_truncate <= in_frame_ff && rx_res_exhausted && rx_at_max_len;
      if (sof_ev) begin
        rx_verdict <= '{discard: 1'b1, default: 1'b0}; // RULE1
      end else if (mof_ev) begin
        rx_verdict <= mof_v;
      end
    end
  end

  // Shortfall statistics; every overrun is counted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sof_cnt_ff <= '0;
      mof_cnt_ff <= '0;
      dma_cnt_ff <= '0;
    end else begin
      if (sof_ev) begin
        sof_cnt_ff <= sof_cnt_ff + 32'h1; // RULE1
      end
      if (mof_ev) begin
        mof_cnt_ff <= mof_cnt_ff + 32'h1; // RULE2 RULE3 RULE4 RULE5
      end
      if ((sof_ev || mof_ev) && rx_dma_short) begin
        dma_cnt_ff <= dma_cnt_ff + 32'h1;
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************

  // Read data mux
  always_comb begin
    nxt_rdata = '0;
    rd_hit = mapped(araddr);
    case (araddr)
      MAC_CONFIG_OFS: nxt_rdata[PRIO_SEL_BIT] = prio_rr_ff;
      DMA_CONTROL_OFS: nxt_rdata[DMA_EN_BIT] = dma_en_ff;
      RX_FILTER_OFS: nxt_rdata[1:0] = {err_copy_ff, copy_all_ff};
      FIFO_CONFIG_OFS: nxt_rdata[LVL_W-1:0] = cell_lvl_ff;
      SHUTDOWN_OFS: nxt_rdata[NUM_CH-1:0] = td_req_ff;
      IRQ_STATUS_OFS: nxt_rdata[NUM_CH-1:0] = irq_ff;
      SOF_CNT_OFS: nxt_rdata = sof_cnt_ff;
      MOF_CNT_OFS: nxt_rdata = mof_cnt_ff;
      DMA_CNT_OFS: nxt_rdata = dma_cnt_ff;
      default: ;
    endcase
    for (int n = 0; n < NUM_CH; n++) begin
      if (araddr == HEAD_BASE + 8'(4 * n)) nxt_rdata = head_ff[n];
      if (araddr == COMP_BASE + 8'(4 * n)) nxt_rdata = comp_ff[n];
    end
  end

  // Read answer registered on the edge that takes the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= nxt_rdata;
      rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

  // ****************************************
  // Checks
  // ****************************************

  sequence s_td_exec;
    td_go;
  endsequence

  // Channel of the stop is taken from the held copy, not the live pick
  sequence s_td_done;
    ##1 (td_fire_ff && head_ff[td_fire_ch_ff] == '0 &&
         comp_ff[td_fire_ch_ff] == DONE_VALUE)
    ##1 irq_ff[$past(td_fire_ch_ff)];
  endsequence

  logic [NUM_CH-1:0] rr_order;
  logic [CH_W-1:0] rr_gap;

  // Pending set seen from the channel after the last grant
  assign rr_order = NUM_CH'({pend, pend} >> (last_ff + CH_W'(1)));
  assign rr_gap = win_ch - last_ff - CH_W'(1);

  a_sof_counted: assert property (@(posedge aclk) disable iff (!aresetn)
    sof_ev |=> sof_cnt_ff == $past(sof_cnt_ff) + 32'h1 && rx_verdict.discard)
    else $error("start overrun not counted"); // RULE1

  a_mof_discard: assert property (@(posedge aclk) disable iff (!aresetn)
    mof_ev && rx_addr_match && !err_copy_ff |=> rx_verdict_valid &&
    rx_verdict.discard && mof_cnt_ff == $past(mof_cnt_ff) + 32'h1)
    else $error("matching overrun not discarded"); // RULE3

  a_promisc_part: assert property (@(posedge aclk) disable iff (!aresetn)
    mof_ev && !rx_addr_match && copy_all_ff && err_copy_ff |=>
    rx_verdict.to_promisc && rx_verdict.unmatched_frame_flag_flag &&
    rx_verdict.ovr_flag && !rx_verdict.discard)
    else $error("promiscuous partial wrong"); // RULE4

  a_match_part: assert property (@(posedge aclk) disable iff (!aresetn)
    mof_ev && rx_addr_match && err_copy_ff |=> rx_verdict.partial &&
    rx_verdict.ovr_flag && !rx_verdict.unmatched_frame_flag_flag)
    else $error("matching partial wrong"); // RULE5

  a_max_no_ovr: assert property (@(posedge aclk) disable iff (!aresetn)
    in_frame_ff && rx_res_exhausted && rx_at_max_len |=>
    rx_truncate && $stable(mof_cnt_ff))
    else $error("overrun at maximum length"); // RULE6

  a_fixed_top: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_sched_req && win_ok && !prio_rr_ff |->
    (pend >> win_ch) == NUM_CH'(1))
    else $error("fixed grant not highest"); // RULE8

  a_rr_rotate: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_sched_req && prio_rr_ff && win_ok |-> rr_order[rr_gap] &&
    (rr_order & ((NUM_CH'(1) << rr_gap) - NUM_CH'(1))) == '0
    ##1 tx_grant_chan == $past(win_ch))
    else $error("rotation skipped a channel"); // RULE9

  a_busy_waits: assert property (@(posedge aclk) disable iff (!aresetn)
    td_go && tx_busy |-> td_ch != tx_busy_chan)
    else $error("busy channel stopped"); // RULE13

  a_td_sequence: assert property (@(posedge aclk) disable iff (!aresetn)
    s_td_exec |-> s_td_done)
    else $error("shutdown steps out of order"); // RULE15 RULE23

  a_enable_kept: assert property (@(posedge aclk) disable iff (!aresetn)
    td_go && !wr_en |=> $stable(dma_en_ff))
    else $error("shutdown changed enable"); // RULE17

  a_start_level: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_cells_present >= cell_lvl_ff |=> tx_start)
    else $error("start level ignored"); // RULE21

endmodule // emac_dp_core

`default_nettype wire

/* testbench/wire_side_model.sv */
// Wire-side partner: asks the scheduler for channels, keeps a frame busy.
// Assumes the core answers a request with a one-cycle grant pulse.
`default_nettype none

module wire_side_model
  import emac_dp_pkg::*;
#(
  parameter int FRAME_CYC = 20
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic go,
  input wire logic tx_grant_valid,
  input wire logic [CH_W-1:0] tx_grant_chan,
  output logic tx_sched_req,
  output logic tx_busy,
  output logic [CH_W-1:0] tx_busy_chan
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_ff;

  // One request for each go pulse from the bench
  always_ff @(posedge aclk) begin
    if (!aresetn) tx_sched_req <= 1'b0;
    else tx_sched_req <= go;
  end

  // A granted frame stays on the wire for FRAME_CYC cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_busy <= 1'b0;
      left_ff <= 8'h00;
    end else if (tx_grant_valid) begin
      tx_busy <= 1'b1;
      left_ff <= 8'(FRAME_CYC);
    end else if (left_ff != 8'h00) begin
      left_ff <= left_ff - 8'h01;
      tx_busy <= (left_ff != 8'h01);
    end
  end

  // Idle channel lines toggle so a stale value never looks valid
  always_ff @(posedge aclk) begin
    if (!aresetn) tx_busy_chan <= '0;
    else if (tx_grant_valid) tx_busy_chan <= tx_grant_chan;
    else if (!tx_busy) tx_busy_chan <= ~tx_busy_chan;
  end
endmodule // wire_side_model

`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the MAC data-path core over AXI4-Lite.
// Assumes the wire-side model and the package constants of the core.
`default_nettype none

module tb;
  import emac_dp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = 0;
  logic awvalid = 0;
  logic awready;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 0;
  logic [7:0] araddr = 0;
  logic arvalid = 0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 0;
  logic go = 0;
  logic tx_sched_req, tx_grant_valid, tx_busy, sd_flag_valid, tx_irq;
  logic [2:0] tx_grant_chan, tx_busy_chan;
  sd_flag_t sd_flag, sd_ff;
  logic [4:0] tx_cells_present = 0;
  logic tx_packet_complete = 0;
  logic tx_start, rx_frame_start = 0, rx_frame_end = 0, rx_res_avail = 1;
  logic rx_res_exhausted = 0, rx_addr_match = 0, rx_at_max_len = 0;
  logic rx_dma_short = 0;
  logic rx_verdict_valid, rx_truncate;
  rx_verdict_t rx_verdict, vd_ff;
  logic [2:0] gch_ff;
  logic [31:0] rdv;
  logic [1:0] rsp;
  int sdn = 0, vn = 0, tn = 0, fail_count = 0, n_tests = 0, i;
  logic [7:0] tbl [4] = '{8'haa, 8'hcf, 8'h30, 8'h90};
  logic [2:0] rr [3] = '{3'd2, 3'd5, 3'd2};

  always #2 aclk = ~aclk;

  emac_dp_core u_dut (.*);

  wire_side_model u_wire (.aclk(aclk), .aresetn(aresetn), .go(go),
    .tx_grant_valid(tx_grant_valid), .tx_grant_chan(tx_grant_chan),
    .tx_sched_req(tx_sched_req), .tx_busy(tx_busy),
    .tx_busy_chan(tx_busy_chan));

  // Capture one-cycle pulses so checks can look later
  always @(posedge aclk) begin
    if (tx_grant_valid) gch_ff <= tx_grant_chan;
    if (sd_flag_valid) sd_ff <= sd_flag;
    if (sd_flag_valid) sdn <= sdn + 1;
    if (rx_verdict_valid) vd_ff <= rx_verdict;
    if (rx_verdict_valid) vn <= vn + 1;
    if (rx_truncate) tn <= tn + 1;
  end

  // ********************************
  // Bus tasks and comparison
  // ********************************
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("ERROR %s exp %h got %h", nm, e, g);
      fail_count++;
    end
  endtask

  // Both halves offered together, each released when taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    chk("bvalid", 32'h1, 32'(k < 50));
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    chk("rvalid", 32'h1, 32'(k < 50));
    rdv = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(nm, e, rdv);
  endtask

  task go_w();
    @(posedge aclk);
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  task ts(input logic [4:0] c, input logic p, input logic e);
    @(posedge aclk);
    tx_cells_present <= c;
    tx_packet_complete <= p;
    repeat (3) @(posedge aclk);
    chk("tx_start", e, tx_start);
  endtask

  // A frame overrun only when it started with resources
  task rxf(input logic m, input logic mx, input logic av);
    @(posedge aclk);
    rx_addr_match <= m;
    rx_at_max_len <= mx;
    rx_res_avail <= av;
    rx_frame_start <= 1'b1;
    @(posedge aclk);
    rx_frame_start <= 1'b0;
    rx_res_exhausted <= av;
    @(posedge aclk);
    rx_res_exhausted <= 1'b0;
    rx_frame_end <= 1'b1;
    @(posedge aclk);
    rx_frame_end <= 1'b0;
    rx_res_avail <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask

  task stop_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ********************************
  // Scenarios
  // ********************************
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("cell_level", FIFO_CONFIG_OFS, 32'h18);
    rd(8'hfc);
    chk("unmapped_resp", RESP_SLVERR, rsp);
    chk("unmapped_data", 32'h0, rdv);
    wr(8'hfc, 32'h1);
    chk("wr_slverr", RESP_SLVERR, rsp);
    for (i = 0; i < 8; i++) wr(HEAD_BASE + 8'(4 * i), 32'h0);
    wr(MAC_CONFIG_OFS, 32'h1);
    chk("wr_okay", RESP_OKAY, rsp);
    wr(DMA_CONTROL_OFS, 32'h1);
    wr(HEAD_BASE + 8'h08, 32'h100);
    wr(HEAD_BASE + 8'h14, 32'h200);
    for (i = 0; i < 3; i++) begin
      go_w();
      chk("rr_grant", rr[i], gch_ff);
    end
    wr(MAC_CONFIG_OFS, 32'h0);
    go_w();
    chk("fixed_grant", 32'h5, gch_ff);
    // Shutdown lands while channel 5 still has a frame on the wire
    wr(SHUTDOWN_OFS, 32'h5);
    chk("irq_early", 32'h0, tx_irq);
    chk("flag_early", 32'h0, sdn);
    repeat (30) @(posedge aclk);
    chk("irq_raised", 32'h1, tx_irq);
    chk("flag_count", 32'h1, sdn);
    chk("flag_chan", 32'h5, sd_ff.chan);
    chk("flag_addr", 32'h200, sd_ff.desc_addr);
    rchk("head5", HEAD_BASE + 8'h14, 32'h0);
    rchk("comp5", COMP_BASE + 8'h14, DONE_VALUE);
    rchk("dma_en", DMA_CONTROL_OFS, 32'h1);
    rchk("irq_mask", IRQ_STATUS_OFS, 32'h20);
    wr(COMP_BASE + 8'h14, DONE_VALUE);
    repeat (3) @(posedge aclk);
    chk("irq_ack", 32'h0, tx_irq);
    go_w();
    chk("after_stop", 32'h2, gch_ff);
    wr(SHUTDOWN_OFS, 32'h1);
    repeat (5) @(posedge aclk);
    chk("idle_irq", 32'h1, tx_irq);
    chk("idle_flag", 32'h1, sdn);
    rchk("comp1", COMP_BASE + 8'h04, DONE_VALUE);
    wr(COMP_BASE + 8'h04, DONE_VALUE);
    repeat (3) @(posedge aclk);
    chk("idle_ack", 32'h0, tx_irq);
    ts(5'd23, 1'b0, 1'b0);
    ts(5'd24, 1'b0, 1'b1);
    ts(5'd2, 1'b1, 1'b1);
    wr(FIFO_CONFIG_OFS, 32'h8);
    ts(5'd8, 1'b0, 1'b1);
    ts(5'd7, 1'b0, 1'b0);
    rx_dma_short <= 1'b1;
    rxf(1'b1, 1'b0, 1'b0);
    chk("sof_verdict", 32'h10, vd_ff);
    rchk("sof_count", SOF_CNT_OFS, 32'h1);
    for (i = 0; i < 4; i++) begin
      wr(RX_FILTER_OFS, {30'h0, tbl[i][7:6]});
      rxf(tbl[i][5], 1'b0, 1'b1);
      chk("mof_verdict", tbl[i][4:0], vd_ff);
    end
    rchk("mof_count", MOF_CNT_OFS, 32'h4);
    wr(RX_FILTER_OFS, 32'h2);
    rxf(1'b1, 1'b1, 1'b1);
    chk("max_verdicts", 32'h5, vn);
    chk("truncated", 32'h1, tn);
    rchk("max_mof", MOF_CNT_OFS, 32'h4);
    rchk("dma_count", DMA_CNT_OFS, 32'h5);
    stop_test();
  end

  // Run takes a few hundred cycles; this cuts a hang short
  initial begin
    #40000;
    $display("ERROR watchdog exp finish got timeout");
    fail_count++;
    stop_test();
  end
endmodule // tb

`default_nettype wire
